/* rtl/usp_pkg.sv */
// Constants and carrier types for the serial-to-SPI byte bridge.
// Assumes CLOCK_I is the subsystem clock that times both links.
package usp_pkg;
  localparam int          CLK_HZ         = 200_000_000;
  localparam int          CLK_PERIOD_NS  = 5;
  localparam int          BAUD_BPS       = 9600;
  localparam logic [15:0] BIT_PERIOD_CNT = 16'(CLK_HZ / BAUD_BPS);
  localparam logic [15:0] HALF_BIT_CNT   = 16'(CLK_HZ / BAUD_BPS / 2);
  localparam logic [7:0]  SPI_DIV_DEF    = 8'H01;
  localparam int          DATA_BITS      = 8;
  localparam logic [2:0]  LAST_BIT       = 3'H7;
  localparam logic [3:0]  LAST_EDGE      = 4'HF;
  localparam int          FIFO_DEPTH     = 32;
  localparam logic        LINE_IDLE      = 1'H1;

  typedef enum logic [3:0] {
    RX_IDLE = 4'H1, RX_START = 4'H2, RX_DATA = 4'H4, RX_STOP = 4'H8
  } usp_rx_e;
  typedef enum logic [3:0] {
    TX_IDLE = 4'H1, TX_START = 4'H2, TX_DATA = 4'H4, TX_STOP = 4'H8
  } usp_tx_e;
  typedef enum logic [1:0] {
    SPI_IDLE = 2'H1, SPI_RUN = 2'H2
  } usp_spi_e;

  // One byte with its presence bit
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } usp_hold_s;
endpackage : usp_pkg

/* rtl/usp_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; the drain side may stall freely.
`timescale 1ns/100ps
`default_nettype none
module usp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  // Honest full and empty from the occupancy count
  assign in_ready_o  = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = mem[rd_ptr];

  // Storage has no reset; only pointers and count carry reset state
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // Pointers wrap naturally since depth is a power of two
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'H1;
      if (pop) rd_ptr <= rd_ptr + 1'H1;
      if (push && !pop) count <= count + 1'H1;
      else if (pop && !push) count <= count - 1'H1;
    end
  end
endmodule : usp_fifo
`default_nettype wire

/* rtl/usp_bridge.sv */
// Serial-to-SPI bridge: serial bytes in go out over SPI, replies go back.
// Assumes CLOCK_I is the subsystem clock and all inputs are synchronous.
// What this block does
// - SPI master, three wires, idle-low clock
// - SPI runs only after a received serial byte
// - Serial byte out over SPI, reply returned
// - Done flag, then start, eight bits, stop
// - Falling edge on idle line starts reception
// - Sample eight bits, hand byte to SPI
// - Serial reception continues while a reply is sent
// - Eight bits, LSB first, no parity, one stop
// - Next queued byte waits in the FIFO until the reply is sent
// - A held reply blocks the next SPI exchange
// - Bit period is clock over baud rate
// - SPI clock is half the subsystem clock
// - Default serial rate is 9600 bps
// - Back-to-back serial bytes queue up to 32 deep; more are dropped
// - No SPI transfer while serial send busy
// - SPI divider keeps clock within slave limit
`timescale 1ns/100ps
`default_nettype none
module usp_bridge #(
  parameter logic [15:0] BIT_PERIOD   = usp_pkg::BIT_PERIOD_CNT,
  parameter logic [15:0] HALF_BIT     = usp_pkg::HALF_BIT_CNT,
  parameter logic [7:0]  SPI_DIV_HALF = usp_pkg::SPI_DIV_DEF
) (
  input  wire logic CLOCK_I,
  input  wire logic RSTN_I,
  input  wire logic UART_RX_I,
  output logic      UART_TX_O,
  output logic      SPI_SCLK_O,
  output logic      SPI_MOSI_O,
  input  wire logic SPI_MISO_I,
  output logic      SPI_RX_DONE_O,
  output logic      RX_FIFO_READY_O
);
  import usp_pkg::*;

  usp_rx_e    rx_state;
  usp_tx_e    tx_state;
  usp_spi_e   spi_state;
  logic       rx_prev;
  logic [15:0] rx_timer;
  logic [2:0] rx_bit;
  logic [7:0] rx_sh;
  logic       rx_push;
  logic       fifo_valid;
  logic [7:0] fifo_data;
  logic       spi_start;
  logic [7:0] spi_div;
  logic       spi_tick;
  logic       spi_rise;
  logic       spi_fall;
  logic       spi_last;
  logic [3:0] spi_edge;
  logic [7:0] spi_tx_sh;
  logic [7:0] spi_rx_sh;
  logic [7:0] next_rx;
  logic       spi_done;
  usp_hold_s  hold;
  logic       tx_take;
  logic [15:0] tx_timer;
  logic [2:0] tx_bit;
  logic [7:0] tx_sh;

  // Previous line level for falling-edge detection
  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rx_prev <= LINE_IDLE;
    end else begin
      rx_prev <= UART_RX_I;
    end
  end

  // Serial receiver; returns to idle mid-stop so the next start is seen
  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rx_state <= RX_IDLE;
      rx_timer <= 16'H0000;
      rx_bit   <= 3'H0;
      rx_sh    <= 8'H00;
      rx_push  <= 1'H0;
    end else begin
      rx_push <= 1'H0;
      case (rx_state)
        RX_IDLE: begin
          if (rx_prev && !UART_RX_I) begin
            rx_state <= RX_START;
            rx_timer <= HALF_BIT - 16'H0001;
          end
        end
        RX_START: begin
          if (rx_timer == 16'H0000) begin
            // A glitch that is high again at mid-bit is not a start
            if (!UART_RX_I) begin
              rx_state <= RX_DATA;
              rx_timer <= BIT_PERIOD - 16'H0001;
              rx_bit   <= 3'H0;
            end else begin
              rx_state <= RX_IDLE;
            end
          end else begin
            rx_timer <= rx_timer - 16'H0001;
          end
        end
        RX_DATA: begin
          if (rx_timer == 16'H0000) begin
            rx_sh    <= {UART_RX_I, rx_sh[7:1]};
            rx_timer <= BIT_PERIOD - 16'H0001;
            rx_bit   <= rx_bit + 3'H1;
            if (rx_bit == LAST_BIT) begin
              rx_state <= RX_STOP;
            end
          end else begin
            rx_timer <= rx_timer - 16'H0001;
          end
        end
        RX_STOP: begin
          if (rx_timer == 16'H0000) begin
            rx_state <= RX_IDLE;
            // Framing errors are dropped silently
            rx_push  <= UART_RX_I;
          end else begin
            rx_timer <= rx_timer - 16'H0001;
          end
        end
        default: begin
          rx_state <= RX_IDLE;
        end
      endcase
    end
  end

  // Queue decouples reception from the one-at-a-time exchange
  usp_fifo #(
    .WIDTH (DATA_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_i       (CLOCK_I),
    .rstn_i      (RSTN_I),
    .in_valid_i  (rx_push),
    .in_ready_o  (RX_FIFO_READY_O),
    .in_data_i   (rx_sh),
    .out_valid_o (fifo_valid),
    .out_ready_i (spi_start),
    .out_data_o  (fifo_data)
  );

  // Start only with a queued byte, serial transmitter idle and buffer free
  assign spi_start = fifo_valid && (spi_state == SPI_IDLE)
                     && (tx_state == TX_IDLE) && !hold.valid;
  assign spi_tick  = (spi_state == SPI_RUN) && (spi_div == SPI_DIV_HALF - 8'H01);
  assign spi_rise  = spi_tick && !SPI_SCLK_O;
  assign spi_fall  = spi_tick && SPI_SCLK_O;
  assign spi_last  = spi_fall && (spi_edge == LAST_EDGE);
  assign next_rx   = {spi_rx_sh[6:0], SPI_MISO_I};

  // Divider; default toggles each cycle, raise it for slow slaves
  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      spi_div <= 8'H00;
    end else if (spi_state != SPI_RUN || spi_tick) begin
      spi_div <= 8'H00;
    end else begin
      spi_div <= spi_div + 8'H01;
    end
  end

  // SPI master: MOSI changes on rise, MISO sampled on fall, MSB first
  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      spi_state  <= SPI_IDLE;
      SPI_SCLK_O <= 1'H0;
      SPI_MOSI_O <= 1'H0;
      spi_edge   <= 4'H0;
      spi_tx_sh  <= 8'H00;
      spi_rx_sh  <= 8'H00;
    end else begin
      case (spi_state)
        SPI_IDLE: begin
          SPI_SCLK_O <= 1'H0;
          if (spi_start) begin
            spi_state <= SPI_RUN;
            spi_tx_sh <= fifo_data;
            spi_edge  <= 4'H0;
          end
        end
        SPI_RUN: begin
          if (spi_tick) begin
            SPI_SCLK_O <= !SPI_SCLK_O;
            spi_edge   <= spi_edge + 4'H1;
          end
          if (spi_rise) begin
            SPI_MOSI_O <= spi_tx_sh[7];
            spi_tx_sh  <= {spi_tx_sh[6:0], 1'H0};
          end
          if (spi_fall) begin
            spi_rx_sh <= next_rx;
          end
          if (spi_last) begin
            spi_state <= SPI_IDLE;
          end
        end
        default: begin
          spi_state <= SPI_IDLE;
        end
      endcase
    end
  end

  // Done flag is a one-cycle pulse after the last falling edge
  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      spi_done <= 1'H0;
    end else begin
      spi_done <= spi_last;
    end
  end
  assign SPI_RX_DONE_O = spi_done;

  // Holding buffer; a fresh reply beats the transmitter's take
  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      hold <= '0;
    end else if (spi_last) begin
      hold <= '{valid: 1'H1, data: next_rx};
    end else if (tx_take) begin
      hold.valid <= 1'H0;
    end
  end

  assign tx_take = (tx_state == TX_IDLE) && hold.valid;

  // Serial transmitter, each symbol one bit period long
  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      tx_state  <= TX_IDLE;
      UART_TX_O <= LINE_IDLE;
      tx_timer  <= 16'H0000;
      tx_bit    <= 3'H0;
      tx_sh     <= 8'H00;
    end else begin
      case (tx_state)
        TX_IDLE: begin
          UART_TX_O <= LINE_IDLE;
          if (tx_take) begin
            tx_state  <= TX_START;
            tx_sh     <= hold.data;
            UART_TX_O <= 1'H0;
            tx_timer  <= BIT_PERIOD - 16'H0001;
          end
        end
        TX_START: begin
          if (tx_timer == 16'H0000) begin
            tx_state  <= TX_DATA;
            UART_TX_O <= tx_sh[0];
            tx_sh     <= {1'H0, tx_sh[7:1]};
            tx_bit    <= 3'H0;
            tx_timer  <= BIT_PERIOD - 16'H0001;
          end else begin
            tx_timer <= tx_timer - 16'H0001;
          end
        end
        TX_DATA: begin
          if (tx_timer == 16'H0000) begin
            tx_timer <= BIT_PERIOD - 16'H0001;
            tx_bit   <= tx_bit + 3'H1;
            if (tx_bit == LAST_BIT) begin
              tx_state  <= TX_STOP;
              UART_TX_O <= LINE_IDLE;
            end else begin
              UART_TX_O <= tx_sh[0];
              tx_sh     <= {1'H0, tx_sh[7:1]};
            end
          end else begin
            tx_timer <= tx_timer - 16'H0001;
          end
        end
        TX_STOP: begin
          if (tx_timer == 16'H0000) begin
            tx_state <= TX_IDLE;
          end else begin
            tx_timer <= tx_timer - 16'H0001;
          end
        end
        default: begin
          tx_state <= TX_IDLE;
        end
      endcase
    end
  end

  // Checks on the design's own outputs and states
  a_tx_idle_high: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    (tx_state == TX_IDLE) && $past(tx_state == TX_IDLE) |-> UART_TX_O)
    else $error("serial output not high while idle");

  a_tx_start_low: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    $rose(tx_state == TX_START) |-> !UART_TX_O && $past(hold.valid))
    else $error("start bit not low or no held byte");

  a_tx_stop_high: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    (tx_state == TX_STOP) |-> UART_TX_O)
    else $error("stop bit not high");

  a_spi_needs_byte: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    $rose(spi_state == SPI_RUN) |-> $past(fifo_valid) && $past(tx_state == TX_IDLE))
    else $error("SPI began without a queued byte");

  a_spi_tx_apart: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    (spi_state == SPI_RUN) |-> (tx_state == TX_IDLE))
    else $error("SPI ran during serial transmit");

  a_sclk_idle_low: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    (spi_state == SPI_IDLE) |-> !SPI_SCLK_O)
    else $error("SPI clock not low while idle");

  a_done_pulse: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    spi_done |-> hold.valid ##1 !spi_done)
    else $error("done flag not a single pulse with data");

  a_hold_newest: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    spi_last |=> hold.valid && (hold.data == $past(next_rx)))
    else $error("holding buffer missed newest byte");

  a_rx_half_wait: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    $rose(rx_state == RX_START) |-> (rx_timer == HALF_BIT - 16'H0001))
    else $error("start wait not a half bit");

  a_rx_push_stop: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    rx_push |-> $past(rx_state == RX_STOP) && $past(UART_RX_I) && (rx_state == RX_IDLE))
    else $error("byte queued outside a valid stop bit");

  // Data may only move together with a rising SPI clock
  a_mosi_on_rise: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    $changed(SPI_MOSI_O) |-> $rose(SPI_SCLK_O))
    else $error("MOSI moved off a rising SPI clock");

  // A held reply blocks the next exchange, so nothing is overwritten
  a_spi_hold_free: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    $rose(spi_state == SPI_RUN) |-> !$past(hold.valid))
    else $error("SPI began while a reply was held");

  a_done_after_run: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
    spi_done |-> $past(spi_state == SPI_RUN))
    else $error("done flag without a finished transfer");
endmodule : usp_bridge
`default_nettype wire

/* tb/usp_spi_slave_model.sv */
// Behavioural SPI slave for the bridge bench: mode 1, MSB first both ways.
// Assumes the master moves data on the rising clock edge and samples on the fall.
`timescale 1ns/100ps
`default_nettype none
module usp_spi_slave_model (
  input  wire logic       sclk_i,
  input  wire logic       mosi_i,
  input  wire logic [7:0] reply_i,
  output logic            miso_o,
  output logic [7:0]      got_o,
  output logic [7:0]      frames_o
);
  logic [7:0] shift_in;
  logic [2:0] bit_cnt;

  // A real slave has no reset pin, so start from a known state
  initial begin
    miso_o   = 1'H1;
    got_o    = 8'H00;
    frames_o = 8'H00;
    shift_in = 8'H00;
    bit_cnt  = 3'H0;
  end

  // Next reply bit appears on each rising edge
  always @(posedge sclk_i) begin
    miso_o <= reply_i[3'H7 - bit_cnt];
  end

  // Take master data on the fall; line has no pull, so show the opposite bit after a frame
  always @(negedge sclk_i) begin
    shift_in = {shift_in[6:0], mosi_i};
    bit_cnt <= bit_cnt + 3'H1;
    if (bit_cnt == 3'H7) begin
      got_o    <= shift_in;
      frames_o <= frames_o + 8'H01;
      miso_o   <= ~miso_o;
    end
  end
endmodule : usp_spi_slave_model
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the serial-to-SPI bridge; the bench plays the serial host.
// Assumes short bit counts (32 and 16 cycles) and an SPI clock of half the core clock.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import usp_pkg::*;
  localparam int BITS = 32;
  localparam int HALF = 16;

  logic       clk;
  logic       rstn;
  logic       uart_rx;
  logic       uart_tx;
  logic       sclk;
  logic       mosi;
  logic       miso;
  logic       rx_done;
  logic       fifo_ready;
  logic [7:0] slv_reply;
  logic [7:0] slv_got;
  logic [7:0] slv_frames;
  logic       in_frame;
  int         mismatches;
  int         total_checks;
  int         overlaps;
  int         dones;
  logic [7:0] replies [4] = '{8'H3C, 8'HFE, 8'H7F, 8'HC3};
  logic [7:0] sent    [4] = '{8'HA5, 8'H01, 8'H80, 8'H5A};

  assign slv_reply = replies[slv_frames[1:0]];

  usp_bridge #(.BIT_PERIOD(16'H0020), .HALF_BIT(16'H0010), .SPI_DIV_HALF(8'H01)) i_dut (
    .CLOCK_I(clk), .RSTN_I(rstn), .UART_RX_I(uart_rx), .UART_TX_O(uart_tx),
    .SPI_SCLK_O(sclk), .SPI_MOSI_O(mosi), .SPI_MISO_I(miso),
    .SPI_RX_DONE_O(rx_done), .RX_FIFO_READY_O(fifo_ready)
  );

  usp_spi_slave_model i_slave (
    .sclk_i(sclk), .mosi_i(mosi), .reply_i(slv_reply),
    .miso_o(miso), .got_o(slv_got), .frames_o(slv_frames)
  );

  // 200 MHz core clock
  initial begin
    clk = 1'H0;
    forever #2.5 clk = ~clk;
  end

  // SPI must stay quiet while a reply is on the serial line; done pulses are counted
  always @(posedge sclk) if (in_frame === 1'H1) overlaps++;
  always @(negedge clk) if (rx_done === 1'H1) dones++;

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize

  task automatic give_up();
    mismatches++;
    summarize();
  endtask : give_up

  // Host sends one character: start, eight bits LSB first, one stop
  task automatic uart_send(input logic [7:0] b);
    int k;
    uart_rx = 1'H0;
    repeat (BITS) @(negedge clk);
    for (k = 0; k < 8; k++) begin
      uart_rx = b[k];
      repeat (BITS) @(negedge clk);
    end
    uart_rx = 1'H1;
    repeat (BITS) @(negedge clk);
  endtask : uart_send

  // Host receives one character, sampling each bit at its centre
  task automatic uart_get(output logic [7:0] b);
    int k;
    for (k = 0; uart_tx !== 1'H0; k++) begin
      if (k == 4000) give_up();
      @(negedge clk);
    end
    in_frame = 1'H1;
    repeat (HALF) @(negedge clk);
    check({7'H00, uart_tx}, 8'H00);
    for (k = 0; k < 8; k++) begin
      repeat (BITS) @(negedge clk);
      b[k] = uart_tx;
    end
    repeat (BITS) @(negedge clk);
    check({7'H00, uart_tx}, 8'H01);
    in_frame = 1'H0;
  endtask : uart_get

  // Pins at rest after reset
  task automatic test_reset();
    check({7'H00, uart_tx}, 8'H01);
    check({7'H00, sclk}, 8'H00);
    check({7'H00, rx_done}, 8'H00);
    check({7'H00, fifo_ready}, 8'H01);
  endtask : test_reset

  // A short low glitch is no start bit; nothing may move
  task automatic test_idle();
    logic quiet;
    quiet = 1'H1;
    uart_rx = 1'H0;
    repeat (4) @(negedge clk);
    uart_rx = 1'H1;
    repeat (400) begin
      @(negedge clk);
      if (uart_tx !== 1'H1 || sclk !== 1'H0) quiet = 1'H0;
    end
    check({7'H00, quiet}, 8'H01);
    check(slv_frames, 8'H00);
  endtask : test_idle

  // One exchange, with the SPI clock period measured rise to rise
  task automatic test_single();
    logic [7:0] r;
    int         n;
    int         k;
    fork
      uart_send(sent[0]);
      begin
        for (k = 0; sclk !== 1'H1; k++) begin
          if (k == 2000) give_up();
          @(negedge clk);
        end
        n = 0;
        do begin
          @(negedge clk);
          n++;
        end while (sclk !== 1'H1 && n < 8);
        check(8'(n), 8'H02);
      end
      uart_get(r);
    join
    check(slv_got, sent[0]);
    check(r, replies[0]);
  endtask : test_single

  // Back-to-back characters: none lost, replies in order, no overlap
  task automatic test_burst();
    logic [7:0] r;
    int         k;
    fork
      for (int i = 1; i < 4; i++) uart_send(sent[i]);
      for (k = 1; k < 4; k++) begin
        uart_get(r);
        check(slv_got, sent[k]);
        check(r, replies[k]);
      end
    join
    repeat (400) @(negedge clk);
    check(8'(overlaps), 8'H00);
    check(slv_frames, 8'H04);
    check(8'(dones), 8'H04);
    check({7'H00, uart_tx}, 8'H01);
  endtask : test_burst

  // Main sequence
  initial begin
    rstn = 1'H0;
    uart_rx = 1'H1;
    in_frame = 1'H0;
    mismatches = 0;
    total_checks = 0;
    overlaps = 0;
    dones = 0;
    repeat (6) @(negedge clk);
    test_reset();
    rstn = 1'H1;
    repeat (2) @(negedge clk);
    test_reset();
    test_idle();
    test_single();
    test_burst();
    summarize();
  end
endmodule : tb_top
`default_nettype wire
